// [design/pmuc_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef PMUC_MAP_SVH
`define PMUC_MAP_SVH

`define PMUC_OFF_CONTROL 6'h00
`define PMUC_OFF_KEY 6'h04
`define PMUC_OFF_ADDR_LO 6'h08
`define PMUC_OFF_ADDR_HI 6'h0C
`define PMUC_OFF_WORD_LO 6'h10
`define PMUC_OFF_WORD_HI 6'h14
`define PMUC_OFF_IRQ_STAT 6'h18
`define PMUC_OFF_IRQ_MASK 6'h1C

`define PMUC_BIT_READ 0
`define PMUC_BIT_START 1
`define PMUC_BIT_PERMIT 2
`define PMUC_BIT_FAULT 3
`define PMUC_BIT_FREE 4
`define PMUC_BIT_LATCH_ONLY 5
`define PMUC_BIT_CFG_SEL 6
`define PMUC_BIT_CTRL_TOP 7

`define PMUC_KEY_FIRST 8'h55
`define PMUC_KEY_SECOND 8'hAA
`define PMUC_KEY_RESET 8'h00

`define PMUC_IRQ_DONE 0
`define PMUC_IRQ_FAULT 1

`define PMUC_CYCLE_NS 1000
`define PMUC_CLK_NS 50
`define PMUC_CYCLE_CNT (`PMUC_CYCLE_NS / `PMUC_CLK_NS)

`endif

// [design/pmuc_pkg.sv]
// Types shared by the program memory unlock control block
package pmuc_pkg;

    typedef enum logic [1:0] {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_HALF = 2'b01,
        UNLOCK_OPEN = 2'b10
    } pmuc_unlock_e;

    typedef struct packed {
        logic cfg_sel;
        logic latch_only;
        logic free;
        logic [14:0] addr;
        logic [13:0] word;
    } pmuc_cmd_s;

endpackage

// [design/pmuc_cycle_timer.sv]
// Busy timer that stands for one program cycle of the memory array
`timescale 1ns/1ps
`default_nettype none
`include "pmuc_map.svh"

module pmuc_cycle_timer #(
    parameter int CYCLES = `PMUC_CYCLE_CNT
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);

    logic [15:0] count;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            count <= 16'h0000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                count <= 16'(CYCLES - 1);
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (count == 16'h0000) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end

endmodule
`default_nettype wire

// [design/pmuc_top.sv]
// Program memory unlock control with a classic Wishbone register slave
// How it works
// - A program cycle starts only if 55h then AAh went to the key register.
// - The key register is 8 bits, write-only, reads zero and resets to zero.
// - Bit 7 of the control and high address registers always reads one.
// - The high word register keeps bits 5 to 0; bits 7 and 6 read zero.
`timescale 1ns/1ps
`default_nettype none
`include "pmuc_map.svh"

module pmuc_top #(
    parameter int CYCLES = `PMUC_CYCLE_CNT
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic prog_start_o,
    output pmuc_pkg::pmuc_cmd_s prog_cmd_o,
    output logic prog_busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    pmuc_pkg::pmuc_unlock_e unlock;
    logic [7:0] key;
    logic cfg_sel, latch_only, free, permit, fault, rd_bit;
    logic [7:0] addr_lo, word_lo;
    logic [6:0] addr_hi;
    logic [5:0] word_hi;
    logic [1:0] irq_stat, irq_mask;
    logic start_req, busy, done;

    logic req, wr, wr_lane0;
    logic [7:0] wbyte;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign wr_lane0 = wr && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic hit_control;
    logic hit_key;
    logic hit_addr_lo;
    logic hit_addr_hi;
    logic hit_word_lo;
    logic hit_word_hi;
    logic hit_irq_stat;
    logic hit_irq_mask;
    assign hit_control = wb_adr_i == `PMUC_OFF_CONTROL;
    assign hit_key = wb_adr_i == `PMUC_OFF_KEY;
    assign hit_addr_lo = wb_adr_i == `PMUC_OFF_ADDR_LO;
    assign hit_addr_hi = wb_adr_i == `PMUC_OFF_ADDR_HI;
    assign hit_word_lo = wb_adr_i == `PMUC_OFF_WORD_LO;
    assign hit_word_hi = wb_adr_i == `PMUC_OFF_WORD_HI;
    assign hit_irq_stat = wb_adr_i == `PMUC_OFF_IRQ_STAT;
    assign hit_irq_mask = wb_adr_i == `PMUC_OFF_IRQ_MASK;

    logic ctrl_wr;
    assign ctrl_wr = wr_lane0 && hit_control;

    ////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait state, ack drops the cycle after

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        unique case (wb_adr_i)
            `PMUC_OFF_CONTROL: begin
                next_rdata = {1'b1, cfg_sel, latch_only, free,
                    fault, permit, busy, rd_bit};
            end
            `PMUC_OFF_KEY: begin
                next_rdata = 8'h00;
            end
            `PMUC_OFF_ADDR_LO: begin
                next_rdata = addr_lo;
            end
            `PMUC_OFF_ADDR_HI: begin
                next_rdata = {1'b1, addr_hi};
            end
            `PMUC_OFF_WORD_LO: begin
                next_rdata = word_lo;
            end
            `PMUC_OFF_WORD_HI: begin
                next_rdata = {2'b00, word_hi};
            end
            `PMUC_OFF_IRQ_STAT: begin
                next_rdata = {6'h00, irq_stat};
            end
            `PMUC_OFF_IRQ_MASK: begin
                next_rdata = {6'h00, irq_mask};
            end
            // Unmapped offsets read zero and are still answered
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // Upper lanes are never used, so they stay zero
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= {24'h000000, next_rdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain data registers

    // Frozen while busy so a running cycle never sees its operands move
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            addr_lo <= 8'h00;
        end else if (wr_lane0 && hit_addr_lo && !busy) begin
            addr_lo <= wbyte;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            addr_hi <= 7'h00;
        end else if (wr_lane0 && hit_addr_hi && !busy) begin
            addr_hi <= wbyte[6:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            word_lo <= 8'h00;
        end else if (wr_lane0 && hit_word_lo && !busy) begin
            word_lo <= wbyte;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            word_hi <= 6'h00;
        end else if (wr_lane0 && hit_word_hi && !busy) begin
            word_hi <= wbyte[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cfg_sel <= 1'b0;
            latch_only <= 1'b0;
            free <= 1'b0;
        end else if (ctrl_wr && !busy) begin
            cfg_sel <= wbyte[`PMUC_BIT_CFG_SEL];
            latch_only <= wbyte[`PMUC_BIT_LATCH_ONLY];
            free <= wbyte[`PMUC_BIT_FREE];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            permit <= 1'b0;
        end else if (ctrl_wr && !busy) begin
            permit <= wbyte[`PMUC_BIT_PERMIT];
        end
    end

    // No array reads here, so the read request bit never sets
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rd_bit <= 1'b0;
        end else if (ctrl_wr && !busy) begin
            rd_bit <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unlock sequence

    logic key_wr, start_wr;
    assign key_wr = wr_lane0 && hit_key;
    assign start_wr = ctrl_wr && wbyte[`PMUC_BIT_START];

    // Write-only key holds the last value, cleared by every reset
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            key <= `PMUC_KEY_RESET;
        end else if (key_wr) begin
            key <= wbyte;
        end
    end

    pmuc_pkg::pmuc_unlock_e next_unlock;

    // Unlock lapses on any other access; timing is left to software
    always_comb begin
        next_unlock = unlock;
        if (req) begin
            unique case (unlock)
                pmuc_pkg::UNLOCK_IDLE: begin
                    if (key_wr && wbyte == `PMUC_KEY_FIRST) begin
                        next_unlock = pmuc_pkg::UNLOCK_HALF;
                    end else begin
                        next_unlock = pmuc_pkg::UNLOCK_IDLE;
                    end
                end
                pmuc_pkg::UNLOCK_HALF: begin
                    if (key_wr && wbyte == `PMUC_KEY_SECOND
                        && key == `PMUC_KEY_FIRST) begin
                        next_unlock = pmuc_pkg::UNLOCK_OPEN;
                    end else begin
                        next_unlock = pmuc_pkg::UNLOCK_IDLE;
                    end
                end
                pmuc_pkg::UNLOCK_OPEN: begin
                    next_unlock = pmuc_pkg::UNLOCK_IDLE;
                end
                default: begin
                    next_unlock = pmuc_pkg::UNLOCK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            unlock <= pmuc_pkg::UNLOCK_IDLE;
        end else begin
            unlock <= next_unlock;
        end
    end

    // Start only straight after the full key, with the permit bit set
    assign start_req = start_wr && unlock == pmuc_pkg::UNLOCK_OPEN
        && permit && wbyte[`PMUC_BIT_PERMIT] && !busy;

    logic fault_set;
    assign fault_set = start_wr && !start_req && !busy;

    // Start without unlock sets the fault flag; set beats clear
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fault <= 1'b0;
        end else if (fault_set) begin
            fault <= 1'b1;
        end else if (ctrl_wr) begin
            fault <= wbyte[`PMUC_BIT_FAULT] & fault;
        end
    end

    pmuc_cycle_timer #(
        .CYCLES(CYCLES)
    ) u_timer (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .start_i(start_req),
        .busy_o(busy),
        .done_o(done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Program command outputs

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            prog_start_o <= 1'b0;
        end else begin
            prog_start_o <= start_req;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            prog_busy_o <= 1'b0;
        end else begin
            prog_busy_o <= busy;
        end
    end

    // Captured once so later register writes cannot disturb it
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            prog_cmd_o <= '0;
        end else if (start_req) begin
            prog_cmd_o <= {cfg_sel, latch_only, free, addr_hi, addr_lo,
                word_hi, word_lo};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: write one to clear, set wins

    logic [1:0] ev, clr;
    assign ev = {fault_set, done};
    assign clr = (wr_lane0 && hit_irq_stat) ? wbyte[1:0] : 2'b00;

    // A new event outranks a clear that lands in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            irq_stat <= 2'b00;
        end else begin
            irq_stat <= (irq_stat & ~clr) | ev;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            irq_mask <= 2'b00;
        end else if (wr_lane0 && hit_irq_mask) begin
            irq_mask <= wbyte[1:0];
        end
    end

    // Registered, so the pin lags the status by one cycle
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end

endmodule
`default_nettype wire

// [sim/pmuc_assertions.sv]
// Port checks for the program memory unlock control
`timescale 1ns/1ps
`default_nettype none
`include "pmuc_map.svh"
module pmuc_assertions (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic prog_start_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);
    wire logic rd = wb_ack_o & wb_cyc_i & ~wb_we_i;
    // Start needs start and permit in one written byte
    wire logic go = wb_ack_o & wb_cyc_i & wb_we_i & wb_sel_i[0] &
        wb_dat_i[1] & wb_dat_i[2] & (wb_adr_i == `PMUC_OFF_CONTROL);
    // The start pulse stands in the cycle in which that write is acked
    sequence s_go_acked;
        go;
    endsequence
    sequence s_read_at(logic [5:0] a);
        rd && wb_adr_i == a;
    endsequence
    property p_start;
        prog_start_o |-> s_go_acked;
    endproperty
    a_start: assert property (p_start) else $error("start with no go");
    property p_key;
        s_read_at(`PMUC_OFF_KEY) |-> wb_dat_o == 32'h00000000;
    endproperty
    a_key: assert property (p_key) else $error("key read not zero");
    property p_top;
        s_read_at(`PMUC_OFF_CONTROL) or s_read_at(`PMUC_OFF_ADDR_HI)
            |-> wb_dat_o[7];
    endproperty
    a_top: assert property (p_top) else $error("top bit not one");
    property p_hi;
        s_read_at(`PMUC_OFF_WORD_HI) |-> wb_dat_o[31:6] == 26'h0000000;
    endproperty
    a_hi: assert property (p_hi) else $error("word high bits set");
    property p_ack;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held");
endmodule
bind pmuc_top pmuc_assertions u_pmuc_assertions (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prog_start_o(prog_start_o));
`default_nettype wire

// [sim/program_memory_unlock_control_bench.sv]
// Self-checking bench for the program memory unlock control
`timescale 1ns/1ps
`default_nettype none
`include "pmuc_map.svh"
module program_memory_unlock_control_bench;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [7:0] dat = 8'h00;
    logic [31:0] rdat;
    logic ack, irq, go, busy;
    pmuc_pkg::pmuc_cmd_s cmd;
    logic [7:0] expq[$];
    logic [31:0] rs = 32'h0001662B;
    logic [7:0] lo, hi;
    int mismatches = 0;
    int comparisons = 0;
    int starts = 0;
    // Short program cycle keeps the run brief
    pmuc_top #(.CYCLES(4)) u_pmuc_top (.clk_sys_i(clk_sys_i),
        .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h000000, dat}),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .prog_start_o(go), .prog_cmd_o(cmd), .prog_busy_o(busy));
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    task automatic close_out();
        $display("%0d compared, %0d mismatched", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // Read data is taken at the edge where ack is seen high
    always @(posedge clk_sys_i) begin
        if (go === 1'b1) begin
            starts++;
        end
        if (ack === 1'b1 && we === 1'b0) begin
            chk("read data", {24'h000000, expq.pop_front()}, rdat);
        end
    end
    task automatic bus(logic w, logic [5:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_sys_i);
        while (ack !== 1'b1) begin
            n++;
            if (n > 40) begin
                chk("ack", 1, 0);
                close_out();
            end
            @(posedge clk_sys_i);
        end
        cyc <= 1'b0;
    endtask
    task automatic rd(logic [5:0] a, logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic unlock(logic [7:0] k1, logic [7:0] k2, logic mid,
        logic ok);
        bus(1'b1, `PMUC_OFF_KEY, k1);
        bus(1'b1, `PMUC_OFF_KEY, k2);
        if (mid) begin
            rd(6'h20, 8'h00);
        end
        bus(1'b1, `PMUC_OFF_CONTROL, 8'h06);
        repeat (3) @(negedge clk_sys_i);
        chk("busy", ok, busy);
        for (int n = 0; n < 40 && busy === 1'b1; n++) begin
            @(negedge clk_sys_i);
        end
        repeat (2) @(negedge clk_sys_i);
        chk("busy", 0, busy);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        lo = rnd();
        hi = rnd();
        rd(`PMUC_OFF_KEY, 8'h00);
        rd(`PMUC_OFF_CONTROL, 8'h80);
        bus(1'b1, `PMUC_OFF_KEY, 8'h55);
        rd(`PMUC_OFF_KEY, 8'h00);
        bus(1'b1, `PMUC_OFF_ADDR_HI, hi);
        rd(`PMUC_OFF_ADDR_HI, hi | 8'h80);
        bus(1'b1, `PMUC_OFF_WORD_HI, hi);
        rd(`PMUC_OFF_WORD_HI, hi & 8'h3F);
        bus(1'b1, `PMUC_OFF_WORD_LO, lo);
        bus(1'b1, 6'h20, 8'hFF);
        rd(6'h20, 8'h00);
        $display("test registers done");
        bus(1'b1, `PMUC_OFF_IRQ_MASK, 8'h03);
        bus(1'b1, `PMUC_OFF_CONTROL, 8'h04);
        unlock(8'h55, 8'hAA, 1'b0, 1'b1);
        chk("starts", 1, starts);
        chk("word", {18'h00000, hi[5:0], lo}, 32'(cmd.word));
        chk("cmd", {3'b000, hi[6:0], 8'h00, hi[5:0], lo}, cmd);
        chk("irq", 1, irq);
        bus(1'b1, `PMUC_OFF_IRQ_STAT, 8'h01);
        repeat (3) @(negedge clk_sys_i);
        chk("irq", 0, irq);
        $display("test unlock done");
        unlock(8'hAA, 8'h55, 1'b0, 1'b0);
        chk("starts", 1, starts);
        rd(`PMUC_OFF_CONTROL, 8'h8C);
        bus(1'b1, `PMUC_OFF_IRQ_MASK, 8'h00);
        repeat (3) @(negedge clk_sys_i);
        chk("irq", 0, irq);
        bus(1'b1, `PMUC_OFF_IRQ_MASK, 8'h03);
        repeat (3) @(negedge clk_sys_i);
        chk("irq", 1, irq);
        bus(1'b1, `PMUC_OFF_IRQ_STAT, 8'h02);
        $display("test key order done");
        unlock(8'h55, 8'hAA, 1'b1, 1'b0);
        chk("starts", 1, starts);
        unlock(8'h55, 8'hAA, 1'b0, 1'b1);
        chk("starts", 2, starts);
        $display("test intervening access done");
        @(posedge clk_sys_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        rd(`PMUC_OFF_CONTROL, 8'h80);
        rd(`PMUC_OFF_IRQ_STAT, 8'h00);
        chk("irq", 0, irq);
        $display("test reset done");
        close_out();
    end
endmodule
`default_nettype wire
